// *** logic/cfr_map.svh ***
`ifndef CFR_MAP_SVH
`define CFR_MAP_SVH

`define CFR_CLK_HZ 50000000
`define CFR_BLINK_HZ 4
`define CFR_BLINK_HALF_CYC (`CFR_CLK_HZ / (2 * `CFR_BLINK_HZ))
`define CFR_BLINK_CNT_W 23
`define CFR_ACT_HOLD_CYC 8
`define CFR_BYTE_W 8

`endif

// *** logic/cfr_pkg.sv ***
`include "cfr_map.svh"

package cfr_pkg;
    // one gmii-style byte lane with frame markers
    typedef struct packed {
        logic [`CFR_BYTE_W-1:0] data;
        logic en;
        logic er;
    } cfr_lane_s;

    typedef enum logic [2:0] {
        CFR_DOWN = 3'b001,
        CFR_FAULT = 3'b010,
        CFR_UP = 3'b100
    } cfr_link_e;
endpackage : cfr_pkg

// *** logic/cfr_blinker.sv ***
`timescale 1ns/1ns
`include "cfr_map.svh"

module cfr_blinker
    import cfr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_link_up,
    input wire logic i_activity,
    output logic o_lamp
);
    parameter int unsigned HALF_CYC = `CFR_BLINK_HALF_CYC;

    logic [`CFR_BLINK_CNT_W-1:0] cnt_r;
    logic phase_r;
    logic [3:0] hold_r;

    // ----------------------------------------
    // blink timebase
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst || cnt_r == `CFR_BLINK_CNT_W'(HALF_CYC - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            phase_r <= 1'b0;
        end else if (cnt_r == `CFR_BLINK_CNT_W'(HALF_CYC - 1)) begin
            phase_r <= ~phase_r;
        end
    end

    // ----------------------------------------
    // activity stretch
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            hold_r <= '0;
        end else if (i_activity) begin
            hold_r <= 4'(`CFR_ACT_HOLD_CYC);
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_lamp <= 1'b0;
        end else begin
            o_lamp <= i_link_up & ((hold_r == 4'h0) | phase_r);
        end
    end
endmodule : cfr_blinker

// *** logic/cfr_relay.sv ***
`timescale 1ns/1ns
`include "cfr_map.svh"


module cfr_relay
    import cfr_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYC = `CFR_BLINK_HALF_CYC
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_cu_link_ok,
    input wire logic i_fx_rx_ok,
    input wire logic i_fx_remote_fault_notice,
    input wire logic i_fx_signal_detect,
    input wire logic i_sfp_present_n,
    input wire cfr_lane_s i_cu_rx,
    input wire cfr_lane_s i_fx_rx,
    output cfr_lane_s o_fx_tx,
    output cfr_lane_s o_cu_tx,
    output logic o_fx_link_enable,
    output logic o_cu_link_enable,
    output logic o_fx_send_remote_fault_notice,
    output logic o_fx_fault,
    output logic o_fx_full_duplex,
    output logic o_cu_autoneg_enable,
    output logic o_cu_auto_crossover,
    output logic o_link_lamp,
    output logic o_optical_signal_lamp,
    output logic o_sfp_lamp,
    output cfr_link_e o_link_state
);
    cfr_link_e state_r;
    logic fx_ok;
    logic link_up;

    // ----------------------------------------
    // fault pass-through
    // ----------------------------------------
    assign fx_ok = i_fx_rx_ok & ~i_fx_remote_fault_notice & ~i_sfp_present_n;
    assign link_up = (state_r == CFR_UP);

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_r <= CFR_DOWN;
        end else begin
            unique case (state_r)
                CFR_DOWN: begin
                    if (i_cu_link_ok && fx_ok) begin
                        state_r <= CFR_UP;
                    end
                end
                CFR_UP: begin
                    if (!i_cu_link_ok || !fx_ok) begin
                        state_r <= CFR_FAULT;
                    end
                end
                CFR_FAULT: begin
                    state_r <= CFR_DOWN;
                end
                default: begin
                    state_r <= CFR_DOWN;
                end
            endcase
        end
    end

    // combinational so the fiber drop is immediate
    assign o_fx_link_enable = ~i_sys_rst & i_cu_link_ok;
    assign o_cu_link_enable = ~i_sys_rst & fx_ok;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_fx_send_remote_fault_notice <= 1'b0;
            o_fx_fault <= 1'b0;
        end else begin
            o_fx_send_remote_fault_notice <= ~i_fx_rx_ok;
            o_fx_fault <= ~fx_ok;
        end
    end

    // fixed link settings, no user configuration
    assign o_fx_full_duplex = 1'b1;
    assign o_cu_autoneg_enable = 1'b1;
    assign o_cu_auto_crossover = 1'b1;
    assign o_link_state = state_r;

    // ----------------------------------------
    // transparent data path
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_fx_tx <= '0;
            o_cu_tx <= '0;
        end else begin
            // byte per clock, no length counter, no idle insertion
            o_fx_tx <= link_up ? i_cu_rx : '0;
            o_cu_tx <= link_up ? i_fx_rx : '0;
        end
    end

    // ----------------------------------------
    // lamps
    // ----------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_optical_signal_lamp <= 1'b0;
            o_sfp_lamp <= 1'b0;
        end else begin
            o_optical_signal_lamp <= i_fx_signal_detect;
            o_sfp_lamp <= ~i_sfp_present_n;
        end
    end

    cfr_blinker #(
        .HALF_CYC(BLINK_HALF_CYC)
    ) u_blink (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_link_up(link_up),
        .i_activity(link_up & (i_cu_rx.en | i_fx_rx.en)),
        .o_lamp(o_link_lamp)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_fx_drop;
        @(posedge i_clk) disable iff (i_sys_rst) !i_cu_link_ok |-> !o_fx_link_enable;
    endproperty
    a_fx_drop: assert property (p_fx_drop) else $error("fiber not forced down");

    property p_cu_drop;
        @(posedge i_clk) disable iff (i_sys_rst) !fx_ok |-> !o_cu_link_enable;
    endproperty
    a_cu_drop: assert property (p_cu_drop) else $error("copper not forced down");

    property p_notice;
        @(posedge i_clk) disable iff (i_sys_rst) !i_fx_rx_ok |=> o_fx_send_remote_fault_notice;
    endproperty
    a_notice: assert property (p_notice) else $error("remote fault notice not sent");

    property p_rf_fault;
        @(posedge i_clk) disable iff (i_sys_rst) i_fx_remote_fault_notice |=> o_fx_fault;
    endproperty
    a_rf_fault: assert property (p_rf_fault) else $error("fiber fault not reported");

    sequence s_up;
        state_r == CFR_UP;
    endsequence
    sequence s_lost;
        !fx_ok;
    endsequence
    property p_settle;
        @(posedge i_clk) disable iff (i_sys_rst) s_up ##0 s_lost |=> (state_r == CFR_FAULT) ##1 (state_r != CFR_UP);
    endproperty
    a_settle: assert property (p_settle) else $error("fiber did not settle down");

    property p_lamp_off;
        @(posedge i_clk) disable iff (i_sys_rst) !link_up |=> !o_link_lamp;
    endproperty
    a_lamp_off: assert property (p_lamp_off) else $error("link lamp lit while down");

    property p_ol;
        @(posedge i_clk) disable iff (i_sys_rst) ##1 o_optical_signal_lamp == $past(i_fx_signal_detect);
    endproperty
    a_ol: assert property (p_ol) else $error("optical lamp wrong");

    property p_sfp;
        @(posedge i_clk) disable iff (i_sys_rst) ##1 o_sfp_lamp == !$past(i_sfp_present_n);
    endproperty
    a_sfp: assert property (p_sfp) else $error("module lamp wrong");

    property p_pass;
        @(posedge i_clk) disable iff (i_sys_rst) link_up |=> o_fx_tx == $past(i_cu_rx);
    endproperty
    a_pass: assert property (p_pass) else $error("frame byte altered");
endmodule : cfr_relay

// *** verification/cfr_fiber_peer.sv ***
`timescale 1ns/1ns

// ----------------------------------------
// remote fiber partner
// ----------------------------------------
module cfr_fiber_peer
    import cfr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_cut_rx,
    input wire logic i_cut_tx,
    input wire logic i_notice,
    output logic o_rx_ok,
    output logic o_light,
    output logic o_notice,
    output logic o_peer_down
);
    // our receive fiber cut: no sync and no light
    assign o_rx_ok = !i_cut_rx;
    assign o_light = !i_cut_rx;
    // peer loses its receive path and answers with the notice
    assign o_notice = i_cut_tx;
    // peer link drops on its own receive loss or on our notice
    always_ff @(posedge i_clk) begin
        o_peer_down <= i_cut_tx | i_notice;
    end
endmodule : cfr_fiber_peer

// *** verification/tb.sv ***
`timescale 1ns/1ns

// ----------------------------------------
// testbench
// ----------------------------------------
module tb;
    import cfr_pkg::*;
    logic i_clk = 0, i_sys_rst = 1, cu_ok = 0, cut_rx = 1, cut_tx = 0, pres_n = 1, m_on = 0;
    logic rx_ok, light, notice, peer_down, fx_en, cu_en, send_n, fx_fault, fdx, an, mdix, lamp, ol, sfp_l;
    logic m_sn, m_fault, m_ol, m_sfp, m_lamp;
    localparam int HALF = 4;
    localparam int HOLD = 8;
    int m_cnt = 0, m_ph = 0, m_hold = 0;
    cfr_lane_s cu_rx = '0, fx_rx = '0, fx_tx, cu_tx, m_fx, m_cu;
    cfr_link_e st;
    int err_total = 0, cmp_count = 0, m_st = 1;
    wire fxok = rx_ok & !notice & !pres_n;

    cfr_fiber_peer peer (.i_clk(i_clk), .i_cut_rx(cut_rx), .i_cut_tx(cut_tx), .i_notice(send_n),
        .o_rx_ok(rx_ok), .o_light(light), .o_notice(notice), .o_peer_down(peer_down));
    cfr_relay #(.BLINK_HALF_CYC(HALF)) uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cu_link_ok(cu_ok),
        .i_fx_rx_ok(rx_ok), .i_fx_remote_fault_notice(notice), .i_fx_signal_detect(light),
        .i_sfp_present_n(pres_n), .i_cu_rx(cu_rx), .i_fx_rx(fx_rx), .o_fx_tx(fx_tx), .o_cu_tx(cu_tx),
        .o_fx_link_enable(fx_en), .o_cu_link_enable(cu_en), .o_fx_send_remote_fault_notice(send_n),
        .o_fx_fault(fx_fault), .o_fx_full_duplex(fdx), .o_cu_autoneg_enable(an),
        .o_cu_auto_crossover(mdix), .o_link_lamp(lamp), .o_optical_signal_lamp(ol), .o_sfp_lamp(sfp_l),
        .o_link_state(st));

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // ----------------------------------------
    // reference model
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            m_st <= 1;
            {m_fx, m_cu, m_sn, m_fault, m_ol, m_sfp} <= '0;
            m_cnt <= 0;
            m_ph <= 0;
            m_hold <= 0;
            m_lamp <= 1'b0;
        end else begin
            m_fx <= (m_st == 4) ? cu_rx : '0;
            m_cu <= (m_st == 4) ? fx_rx : '0;
            m_sn <= !rx_ok;
            m_fault <= !fxok;
            m_ol <= light;
            m_sfp <= !pres_n;
            // lamp: steady while up, blink phase while traffic is stretched
            m_cnt <= (m_cnt == HALF - 1) ? 0 : m_cnt + 1;
            if (m_cnt == HALF - 1) m_ph <= 1 - m_ph;
            if (m_st == 4 && (cu_rx.en || fx_rx.en)) m_hold <= HOLD;
            else if (m_hold != 0) m_hold <= m_hold - 1;
            m_lamp <= (m_st == 4) && (m_hold == 0 || m_ph == 1);
            if (m_st == 1) m_st <= (cu_ok && fxok) ? 4 : 1;
            else if (m_st == 4) m_st <= (cu_ok && fxok) ? 4 : 2;
            else m_st <= 1;
        end
    end

    always @(negedge i_clk) begin
        if (m_on) begin
            chk(fx_tx, m_fx);
            chk(lamp, m_lamp);
            chk(cu_tx, m_cu);
            chk(st, m_st[2:0]);
            chk(fx_en, cu_ok);
            chk(cu_en, fxok);
            chk(send_n, m_sn);
            chk(fx_fault, m_fault);
            chk(ol, m_ol);
            chk(sfp_l, m_sfp);
            chk(fdx, 1'b1);
            chk(an, 1'b1);
            chk({mdix, an}, 2'b11);
        end
    end

    task automatic run(input int n, input bit act, output int tog);
        logic prev;
        tog = 0;
        prev = lamp;
        repeat (n) begin
            @(negedge i_clk);
            cu_rx <= act ? 10'($urandom) : 10'h000;
            fx_rx <= act ? 10'($urandom) : 10'h000;
            if (lamp !== prev) tog++;
            prev = lamp;
        end
    endtask : run

    initial begin
        int t;
        void'($urandom(32'hC7A9));
        repeat (6) @(negedge i_clk);
        i_sys_rst <= 0;
        m_on <= 1;
        pres_n <= 0;
        cut_rx <= 0;
        cu_ok <= 1;
        run(14, 0, t);
        chk(lamp, 1'b1);
        $display("test link_up done");
        run(200, 1, t);
        chk(t > 8, 1'b1);
        $display("test traffic done");
        cu_ok <= 0;
        run(6, 1, t);
        cu_ok <= 1;
        run(6, 1, t);
        $display("test copper_fault done");
        cut_rx <= 1;
        run(6, 1, t);
        chk(lamp, 1'b0);
        chk(peer_down, 1'b1);
        cut_rx <= 0;
        run(6, 1, t);
        $display("test fiber_rx_fault done");
        cut_tx <= 1;
        run(6, 1, t);
        chk(peer_down, 1'b1);
        chk(st, CFR_DOWN);
        cut_tx <= 0;
        pres_n <= 1;
        run(6, 1, t);
        pres_n <= 0;
        run(6, 1, t);
        $display("test remote_fault_and_slot done");
        print_verdict();
    end

    initial begin
        #1000000;
        err_total++;
        print_verdict();
    end
endmodule : tb
